// File: ofs_supervisor.v
/*
  Output fault supervisor for one channel: APB registers, threshold
  comparators with latency filters, response state machine, setpoint clamp
  and per-phase current limiting.
  Assumes sense codes and currents come from outside the clock domain and
  are synchronised here; initDone, droopMv and switchTick are local.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.vh"
module ofs_supervisor #(
  parameter integer HICCUP_CYC = `OFS_HICCUP_CYC,
  parameter integer TON_CYC    = `OFS_TON_CYC
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [11:0] remoteSensePos,
  input  wire [11:0] remoteSenseNeg,
  input  wire [9:0]  totalCurrent,
  input  wire [55:0] phaseCurrent,
  input  wire        supplyGood,
  input  wire        enablePin,
  input  wire        initDone,
  input  wire [7:0]  droopMv,
  input  wire        switchTick,
  output reg  [11:0] setpointCode,
  output reg         convertOn,
  output reg  [6:0]  phaseSkip,
  output reg         phaseForceLow,
  output reg         phaseTristate,
  output reg         faultOutputN,
  output reg         powerGoodOut,
  output reg         alertN
);
  // ==========================================================
  // state codes
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_SS  = 3'h1;
  localparam [2:0] ST_ON  = 3'h2;
  localparam [2:0] ST_HIC = 3'h3;
  localparam [2:0] ST_LAT = 3'h4;

  // ==========================================================
  // pin synchronisers, two stages before any use
  reg [100:0] syncA_q;
  reg [100:0] syncB_q;
  always @(posedge clk)
  begin
    if (srst)
    begin
      syncA_q <= 101'h0;
      syncB_q <= 101'h0;
    end
    else if (ce)
    begin
      syncA_q <= {enablePin, supplyGood, phaseCurrent, totalCurrent,
                  remoteSenseNeg, remoteSensePos};
      syncB_q <= syncA_q;
    end
  end
  wire [11:0] sPos   = syncB_q[11:0];
  wire [11:0] sNeg   = syncB_q[23:12];
  wire [9:0]  sTotal = syncB_q[33:24];
  wire [55:0] sPhase = syncB_q[89:34];
  wire        sSupGd = syncB_q[90];
  wire        sEnPin = syncB_q[91];

  // ==========================================================
  // registers
  reg        ctrlEn_q;
  reg [11:0] target_q;
  reg [11:0] vMin_q;
  reg [11:0] vMax_q;
  reg [8:0]  ovFaultOfs_q;
  reg [8:0]  ovWarnOfs_q;
  reg [8:0]  uvFaultOfs_q;
  reg [8:0]  uvWarnOfs_q;
  reg [11:0] fixOvThr_q;
  reg [9:0]  ocLimit_q;
  reg [7:0]  phaseLimit_q;
  reg [6:0]  tonMax_q;
  reg [9:0]  resp_q;
  reg [9:0]  status_q;
  reg [9:0]  mask_q;
  reg [2:0]  state_q;
  reg        prebiasLock_q;
  reg        fixOvLock_q;
  reg        runReqOld_q;
  reg [18:0] waitCnt_q;
  reg [12:0] tonTick_q;
  reg [6:0]  tonCnt_q;

  wire acc     = psel && penable;
  wire wrAcc   = acc && pwrite;
  wire clrCmd  = wrAcc && (paddr == `OFS_A_CTRL) && pwdata[`OFS_CTRL_CLR];
  wire runReq  = ctrlEn_q && sEnPin;
  wire enCycle = runReq && !runReqOld_q;
  wire clrAll  = clrCmd || enCycle;
  wire conv    = (state_q == ST_SS) || (state_q == ST_ON);

  // ==========================================================
  // tracking comparisons in signed millivolts
  wire [11:0] clampSp = (target_q > vMax_q) ? vMax_q :
                        (target_q < vMin_q) ? vMin_q : target_q;
  wire signed [13:0] diffMv = $signed({2'b00, sPos}) - $signed({2'b00, sNeg});
  wire signed [13:0] refMv  = $signed({2'b00, clampSp}) + $signed({6'h00, droopMv});
  wire signed [13:0] ovfThr = refMv + $signed({5'h00, ovFaultOfs_q});
  wire signed [13:0] ovwThr = refMv + $signed({5'h00, ovWarnOfs_q});
  wire signed [13:0] uvwThr = refMv - $signed({5'h00, uvWarnOfs_q});
  wire signed [13:0] uvfThr = refMv - $signed({5'h00, uvFaultOfs_q});

  wire [5:0] rawCond;
  assign rawCond[0] = initDone && (sPos > fixOvThr_q);
  assign rawCond[1] = conv && (diffMv > ovfThr);
  assign rawCond[2] = conv && (diffMv > ovwThr);
  assign rawCond[3] = conv && (diffMv < uvwThr);
  assign rawCond[4] = conv && (diffMv < uvfThr);
  assign rawCond[5] = conv && (sTotal > ocLimit_q);

  wire [5:0] filt;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_filt
      ofs_latency_filter #(
        .LAT((gi == 5) ? `OFS_OC_CYC :
             ((gi == 2) || (gi == 3)) ? `OFS_LAT2_CYC : `OFS_LAT1_CYC)
      ) u_filt (
        .clk  (clk),
        .srst (srst),
        .ce   (ce),
        .cond (rawCond[gi]),
        .hit  (filt[gi])
      );
    end
  endgenerate

  // per-phase cycle-by-cycle limit
  wire [6:0] phOver;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_phase
      assign phOver[gi] = conv && (sPhase[gi*8 +: 8] > phaseLimit_q);
    end
  endgenerate

  // ==========================================================
  // fault events and their responses
  wire prebiasHit = !initDone && sSupGd && ($signed({2'b00, sPos}) > $signed(`OFS_PREBIAS_MV));
  wire ssReached  = diffMv >= uvfThr;
  wire tonExpire  = (state_q == ST_SS) && (tonCnt_q >= tonMax_q);

  wire [1:0] rFix = resp_q[1:0];
  wire [1:0] rOv  = resp_q[3:2];
  wire [1:0] rUv  = resp_q[5:4];
  wire [1:0] rOc  = resp_q[7:6];
  wire [1:0] rTon = resp_q[9:8];

  // latch or hiccup demand from each fault; ignore acts as a warning
  wire lowLat = (filt[0] && conv && rFix == `OFS_R_LATCH) || (filt[1] && rOv == `OFS_R_LATCH);
  wire lowHic = (filt[0] && conv && rFix == `OFS_R_HICCUP) || (filt[1] && rOv == `OFS_R_HICCUP);
  wire triLat = (filt[4] && rUv == `OFS_R_LATCH) || (filt[5] && rOc == `OFS_R_LATCH) ||
                (tonExpire && rTon == `OFS_R_LATCH);
  wire triHic = (filt[4] && rUv == `OFS_R_HICCUP) || (filt[5] && rOc == `OFS_R_HICCUP) ||
                (tonExpire && rTon == `OFS_R_HICCUP);
  wire shutLow = conv && (lowLat || lowHic);
  wire shutAny = conv && (lowLat || lowHic || triLat || triHic);
  wire goLatch = lowLat || triLat;

  wire [9:0] evt;
  assign evt[`OFS_S_PREBIAS] = prebiasHit;
  assign evt[`OFS_S_FIXOV]   = filt[0];
  assign evt[`OFS_S_TOVF]    = filt[1];
  assign evt[`OFS_S_TOVW]    = filt[2];
  assign evt[`OFS_S_TUVW]    = filt[3];
  assign evt[`OFS_S_TUVF]    = filt[4];
  assign evt[`OFS_S_TON]     = tonExpire;
  assign evt[`OFS_S_VLIM]    = conv && (clampSp != target_q);
  assign evt[`OFS_S_PHOC]    = |phOver;
  assign evt[`OFS_S_OC]      = filt[5];
  // locked bits survive a clear; only a supply cycle removes them
  wire [9:0] keep = {8'h00, fixOvLock_q, prebiasLock_q};

  // ==========================================================
  // status, locks and sequencer
  always @(posedge clk)
  begin
    if (srst)
    begin
      status_q      <= 10'h000;
      prebiasLock_q <= 1'b0;
      fixOvLock_q   <= 1'b0;
      runReqOld_q   <= 1'b0;
      state_q       <= ST_OFF;
      waitCnt_q     <= 19'h00000;
      tonTick_q     <= 13'h0000;
      tonCnt_q      <= 7'h00;
      phaseForceLow <= 1'b0;
      phaseTristate <= 1'b1;
    end
    else if (ce)
    begin
      runReqOld_q <= runReq;
      // set wins over the clear
      if (clrAll)
        status_q <= (status_q & keep) | evt;
      else if (wrAcc && paddr == `OFS_A_STATUS)
        status_q <= (status_q & ~pwdata[9:0]) | evt | keep;
      else
        status_q <= status_q | evt;
      if (!sSupGd)
      begin
        prebiasLock_q <= 1'b0;
        fixOvLock_q   <= 1'b0;
      end
      else
      begin
        if (prebiasHit)
          prebiasLock_q <= 1'b1;
        if (filt[0] && !conv && rFix != `OFS_R_IGNORE)
          fixOvLock_q <= 1'b1;
      end
      if (state_q == ST_SS)
      begin
        if (tonTick_q >= TON_CYC[12:0] - 13'h0001)
        begin
          tonTick_q <= 13'h0000;
          if (tonCnt_q != 7'h7F)
            tonCnt_q <= tonCnt_q + 7'h01;
        end
        else
          tonTick_q <= tonTick_q + 13'h0001;
      end
      else
      begin
        tonTick_q <= 13'h0000;
        tonCnt_q  <= 7'h00;
      end
      if (prebiasLock_q || prebiasHit)
      begin
        state_q       <= ST_LAT;
        phaseForceLow <= 1'b1;
        phaseTristate <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_OFF:
          begin
            phaseForceLow <= fixOvLock_q;
            phaseTristate <= !fixOvLock_q;
            if (runReq && !fixOvLock_q)
              state_q <= ST_SS;
          end
          ST_SS, ST_ON:
          begin
            if (shutAny)
            begin
              // stop at once, driven low for OV, released otherwise
              state_q       <= goLatch ? ST_LAT : ST_HIC;
              waitCnt_q     <= 19'h00000;
              phaseForceLow <= shutLow;
              phaseTristate <= !shutLow;
            end
            else if (!runReq)
            begin
              state_q       <= ST_OFF;
              phaseForceLow <= 1'b0;
              phaseTristate <= 1'b1;
            end
            else
            begin
              phaseForceLow <= 1'b0;
              phaseTristate <= 1'b0;
              if (state_q == ST_SS && ssReached)
                state_q <= ST_ON;
            end
          end
          ST_HIC:
          begin
            if (!runReq)
              state_q <= ST_OFF;
            else if (waitCnt_q >= HICCUP_CYC[18:0] - 19'h00001)
              state_q <= ST_SS;
            else
              waitCnt_q <= waitCnt_q + 19'h00001;
          end
          ST_LAT:
          begin
            if (!runReq || clrCmd)
              state_q <= ST_OFF;
          end
          default:
            state_q <= ST_OFF;
        endcase
      end
    end
  end

  // ==========================================================
  // pin outputs
  wire faultPin = prebiasLock_q || prebiasHit ||
                  (filt[0] && rFix != `OFS_R_IGNORE) ||
                  (filt[1] && rOv != `OFS_R_IGNORE) ||
                  (filt[5] && rOc != `OFS_R_IGNORE);
  always @(posedge clk)
  begin
    if (srst)
    begin
      setpointCode <= 12'h000;
      convertOn    <= 1'b0;
      phaseSkip    <= 7'h00;
      faultOutputN <= 1'b1;
      powerGoodOut <= 1'b0;
      alertN       <= 1'b1;
    end
    else if (ce)
    begin
      setpointCode <= clampSp;
      convertOn    <= conv && !shutAny;
      if (switchTick)
        phaseSkip <= phOver;
      faultOutputN <= !faultPin;
      powerGoodOut <= (state_q == ST_ON) && !shutAny && runReq;
      alertN       <= !(|(status_q & ~mask_q));
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  always @(posedge clk)
  begin
    if (srst)
    begin
      ctrlEn_q     <= 1'b0;
      target_q     <= `OFS_RST_TARGET;
      vMin_q       <= `OFS_RST_VMIN;
      vMax_q       <= `OFS_RST_VMAX;
      ovFaultOfs_q <= `OFS_RST_OVF;
      ovWarnOfs_q  <= `OFS_RST_OVW;
      uvFaultOfs_q <= `OFS_RST_OVF;
      uvWarnOfs_q  <= `OFS_RST_OVW;
      fixOvThr_q   <= `OFS_RST_FIXOV;
      ocLimit_q    <= `OFS_RST_OC;
      phaseLimit_q <= `OFS_RST_PHL;
      tonMax_q     <= `OFS_RST_TON;
      resp_q       <= `OFS_RST_RESP;
      mask_q       <= `OFS_RST_MASK;
      prdata       <= 32'h00000000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        prdata <= 32'h00000000;
        case (paddr)
          `OFS_A_CTRL:   prdata[`OFS_CTRL_EN] <= ctrlEn_q;
          `OFS_A_TARGET: prdata[11:0] <= target_q;
          `OFS_A_VLIMIT: prdata <= {4'h0, vMax_q, 4'h0, vMin_q};
          `OFS_A_OVOFS:  prdata <= {7'h00, ovWarnOfs_q, 7'h00, ovFaultOfs_q};
          `OFS_A_UVOFS:  prdata <= {7'h00, uvWarnOfs_q, 7'h00, uvFaultOfs_q};
          `OFS_A_LIMITS: prdata <= {1'b0, tonMax_q, phaseLimit_q, ocLimit_q[3:0], fixOvThr_q};
          `OFS_A_RESP:   prdata[9:0] <= resp_q;
          `OFS_A_STATUS: prdata[9:0] <= status_q;
          `OFS_A_MASK:   prdata[9:0] <= mask_q;
          `OFS_A_STATE:  prdata <= {16'h0000, ocLimit_q[9:4], fixOvLock_q,
                                    prebiasLock_q, 5'h00, state_q};
          default:       pslverr <= 1'b1;
        endcase
      end
      if (wrAcc && pready)
      begin
        case (paddr)
          `OFS_A_CTRL:   ctrlEn_q <= pwdata[`OFS_CTRL_EN];
          `OFS_A_TARGET: target_q <= pwdata[11:0];
          `OFS_A_VLIMIT:
          begin
            vMin_q <= pwdata[11:0];
            vMax_q <= pwdata[27:16];
          end
          `OFS_A_OVOFS:
          begin
            ovFaultOfs_q <= pwdata[8:0];
            ovWarnOfs_q  <= pwdata[24:16];
          end
          `OFS_A_UVOFS:
          begin
            uvFaultOfs_q <= pwdata[8:0];
            uvWarnOfs_q  <= pwdata[24:16];
          end
          `OFS_A_LIMITS:
          begin
            fixOvThr_q   <= pwdata[11:0];
            phaseLimit_q <= pwdata[23:16];
            tonMax_q     <= pwdata[30:24];
          end
          `OFS_A_STATE:  ocLimit_q <= pwdata[9:0];
          `OFS_A_RESP:   resp_q <= pwdata[9:0];
          `OFS_A_MASK:   mask_q <= pwdata[9:0];
          default:       ctrlEn_q <= ctrlEn_q;
        endcase
      end
    end
  end
endmodule // ofs_supervisor
`default_nettype wire

// File: ofs_consts.vh
/*
  Constants of the output fault supervisor: register offsets, field
  positions, reset values and timing counts.
  Assumes a 20 MHz clock and 32-bit APB with word-aligned registers.
*/
// Operation
// - pre-init pre-bias check against fixed threshold
// - pre-bias trip: phases low, latch, fault out
// - fixed OV after init, power-cycle lock if idle
// - tracking OV fault, configurable response, pulled low
// - tracking OV warning, conversion continues
// - tracking UV warning, conversion continues
// - tracking UV fault, configurable response, tri-stated
// - clamp setpoint to min/max, warning only
// - per-phase current limit, skip pulses, warn
// - latch-off stops; hiccup retries after wait
// - every unmasked status bit raises alert
// - shutdown response drops power-good
`ifndef OFS_CONSTS_VH
`define OFS_CONSTS_VH

// ==========================================================
// register byte offsets
`define OFS_A_CTRL     8'h00
`define OFS_A_TARGET   8'h04
`define OFS_A_VLIMIT   8'h08
`define OFS_A_OVOFS    8'h0C
`define OFS_A_UVOFS    8'h10
`define OFS_A_LIMITS   8'h14
`define OFS_A_RESP     8'h18
`define OFS_A_STATUS   8'h1C
`define OFS_A_MASK     8'h20
`define OFS_A_STATE    8'h24

// ==========================================================
// field positions
`define OFS_CTRL_EN    0
`define OFS_CTRL_CLR   1
`define OFS_HI_LSB     16
`define OFS_TON_LSB    24

// status bit positions
`define OFS_S_PREBIAS  0
`define OFS_S_FIXOV    1
`define OFS_S_TOVF     2
`define OFS_S_TOVW     3
`define OFS_S_TUVW     4
`define OFS_S_TUVF     5
`define OFS_S_TON      6
`define OFS_S_VLIM     7
`define OFS_S_PHOC     8
`define OFS_S_OC       9
`define OFS_NSTAT      10

// response codes, two bits per fault: fixed OV, tracking OV, UV, OC, TON
`define OFS_R_IGNORE   2'h0
`define OFS_R_LATCH    2'h1
`define OFS_R_HICCUP   2'h2

// ==========================================================
// reset values
`define OFS_RST_TARGET 12'h384
`define OFS_RST_VMIN   12'h190
`define OFS_RST_VMAX   12'hA8C
`define OFS_RST_OVF    9'h040
`define OFS_RST_OVW    9'h030
`define OFS_RST_FIXOV  12'hE74
`define OFS_RST_OC     10'h200
`define OFS_RST_PHL    8'h50
`define OFS_RST_TON    7'h28
`define OFS_RST_RESP   10'h155
`define OFS_RST_MASK   10'h000

// ==========================================================
// timing; all voltage codes are millivolts
`define OFS_PREBIAS_MV 14'h0E74
`define OFS_CLK_NS     50
`define OFS_LAT1_NS    1000
`define OFS_LAT2_NS    2000
`define OFS_OC_NS      175000
`define OFS_LAT1_CYC   ((`OFS_LAT1_NS + `OFS_CLK_NS - 1) / `OFS_CLK_NS)
`define OFS_LAT2_CYC   ((`OFS_LAT2_NS + `OFS_CLK_NS - 1) / `OFS_CLK_NS)
`define OFS_OC_CYC     ((`OFS_OC_NS + `OFS_CLK_NS - 1) / `OFS_CLK_NS)
`define OFS_HICCUP_MS  25
`define OFS_TON_US     250
`define OFS_HICCUP_CYC (`OFS_HICCUP_MS * 1000000 / `OFS_CLK_NS)
`define OFS_TON_CYC    (`OFS_TON_US * 1000 / `OFS_CLK_NS)

`endif

// File: ofs_latency_filter.v
/*
  Persistence filter: output rises once the condition has held for LAT
  consecutive enabled cycles and falls as soon as it drops.
  Assumes the condition is already on the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ofs_latency_filter #(
  parameter integer LAT = 20
) (
  input  wire clk,
  input  wire srst,
  input  wire ce,
  input  wire cond,
  output reg  hit
);
  // ==========================================================
  // counter
  reg [11:0] cnt_q;

  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= 12'h000;
      hit   <= 1'b0;
    end
    else if (ce)
    begin
      // a single glitch restarts the count
      if (!cond)
      begin
        cnt_q <= 12'h000;
        hit   <= 1'b0;
      end
      else if (cnt_q >= LAT[11:0] - 12'h001)
        hit <= 1'b1;
      else
        cnt_q <= cnt_q + 12'h001;
    end
  end
endmodule // ofs_latency_filter
`default_nettype wire

// File: ofs_supervisor_chk.sv
/*
  Port checks for the output fault supervisor, bound into it.
  Assumes ce held high and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.vh"
module ofs_supervisor_chk (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] remoteSensePos,
  input wire logic        supplyGood,
  input wire logic        enablePin,
  input wire logic        initDone,
  input wire logic        convertOn,
  input wire logic        phaseForceLow,
  input wire logic        phaseTristate,
  input wire logic        faultOutputN,
  input wire logic        powerGoodOut,
  input wire logic        alertN
);
  // ==========================================================
  // helpers
  logic maskAll;
  logic biasHigh;
  assign maskAll  = psel && penable && pready && pwrite && paddr == `OFS_A_MASK
                    && pwdata[9:0] == 10'h3FF;
  assign biasHigh = !initDone && supplyGood && remoteSensePos > 12'hE74;
  // ==========================================================
  // relations
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_UNMAPPED_ERR: assert property (pready && paddr > `OFS_A_STATE |-> pslverr)
    else $error("unmapped access not flagged");
  AST_LOW_STOPS: assert property (phaseForceLow |-> !convertOn && !powerGoodOut)
    else $error("phases low while converting");
  AST_GOOD_RUNS: assert property (powerGoodOut |-> convertOn && !phaseTristate)
    else $error("power good without conversion");
  AST_ONE_MODE: assert property (phaseForceLow |-> !phaseTristate)
    else $error("low and tri-state together");
  AST_MASK_ALL: assert property (maskAll |=> ##1 alertN)
    else $error("alert with all bits masked");
  // two sync stages plus one register; phases low then pull the node down
  AST_PREBIAS_TRIP: assert property (biasHigh [*4] |-> !faultOutputN && phaseForceLow)
    else $error("pre-bias not caught");
  AST_ENABLE_OFF: assert property ((!enablePin) [*6] |-> !convertOn)
    else $error("converting with enable low");
endmodule // ofs_supervisor_chk
bind ofs_supervisor ofs_supervisor_chk i_ofs_supervisor_chk (
  .clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .remoteSensePos, .supplyGood, .enablePin, .initDone, .convertOn, .phaseForceLow,
  .phaseTristate, .faultOutputN, .powerGoodOut, .alertN);
`default_nettype wire

// File: ofs_stage_model.sv
/*
  Power stage and sense model on the far side of the supervisor.
  Assumes mV codes; errMv and biasMv come from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ofs_stage_model (
  input  wire logic        clk,
  input  wire logic        convertOn,
  input  wire logic [11:0] setpointCode,
  input  wire logic        phaseForceLow,
  input  wire logic [11:0] errMv,
  input  wire logic [11:0] biasMv,
  input  wire logic [7:0]  loadAmps,
  output logic      [11:0] remoteSensePos,
  output logic      [11:0] remoteSenseNeg,
  output logic      [9:0]  totalCurrent,
  output logic      [55:0] phaseCurrent
);
  // ==========================================================
  // output node
  logic [11:0] vOut_q = 12'h000;
  // slew-limited, so soft-start takes real cycles
  always @(posedge clk)
  begin
    if (phaseForceLow)
      vOut_q <= 12'h000;
    else if (!convertOn)
      vOut_q <= biasMv;
    else if (vOut_q + 12'h040 < setpointCode)
      vOut_q <= vOut_q + 12'h040;
    else
      vOut_q <= setpointCode;
  end
  // error only exists while the loop regulates
  assign remoteSensePos = convertOn ? vOut_q + errMv : vOut_q;
  assign remoteSenseNeg = 12'h000;
  assign totalCurrent   = convertOn ? {2'h0, loadAmps} * 10'h007 : 10'h000;
  assign phaseCurrent   = convertOn ? {7{loadAmps}} : 56'h0;
endmodule // ofs_stage_model
`default_nettype wire

// File: tb.sv
/*
  Self-checking bench: APB host tasks and fault scenarios.
  Assumes the stage model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.vh"
module tb;
  // ==========================================================
  // signals
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        supplyGood = 1'b0, enablePin = 1'b0, initDone = 1'b0, switchTick = 1'b0;
  logic [7:0]  paddr = 8'h00, loadAmps = 8'h00;
  logic [11:0] biasMv = 12'h000, errMv = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, e, convertOn, phaseForceLow, phaseTristate;
  logic        faultOutputN, powerGoodOut, alertN;
  logic [11:0] remoteSensePos, remoteSenseNeg, setpointCode;
  logic [9:0]  totalCurrent;
  logic [55:0] phaseCurrent;
  logic [6:0]  phaseSkip;
  int          mismatches = 0, cmp_count = 0, waited;

  ofs_supervisor #(.HICCUP_CYC(200), .TON_CYC(20)) i_ofs_supervisor (
    .clk, .srst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .remoteSensePos, .remoteSenseNeg, .totalCurrent, .phaseCurrent, .supplyGood,
    .enablePin, .initDone, .droopMv(8'h10), .switchTick, .setpointCode, .convertOn,
    .phaseSkip, .phaseForceLow, .phaseTristate, .faultOutputN, .powerGoodOut, .alertN);
  ofs_stage_model i_ofs_stage_model (.clk, .convertOn, .setpointCode, .phaseForceLow,
    .errMv, .biasMv, .loadAmps, .remoteSensePos, .remoteSenseNeg, .totalCurrent,
    .phaseCurrent);

  always #25 clk = ~clk;
  always
  begin
    repeat (8) @(posedge clk);
    switchTick <= 1'b1;
    @(posedge clk);
    switchTick <= 1'b0;
  end

  // ==========================================================
  // tasks
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // idle cycle after each transfer keeps drives one per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      mismatches++;
      stop_test();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdm(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(q & m, exp);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return powerGoodOut;
      1: return !faultOutputN;
      2: return convertOn;
      3: return !convertOn;
      default: return phaseSkip == 7'h7F;
    endcase
  endfunction
  task automatic waitOn(input int k, input int lim);
    waited = 0;
    while (pick(k) !== 1'b1 && waited < lim)
    begin
      @(posedge clk);
      waited++;
    end
    if (waited >= lim)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  // ==========================================================
  // scenarios
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdm(`OFS_A_TARGET, 32'h384, 32'hFFFFFFFF);
    rdm(`OFS_A_VLIMIT, 32'h0A8C0190, 32'hFFFFFFFF);
    rdm(`OFS_A_OVOFS, 32'h00300040, 32'hFFFFFFFF);
    rdm(`OFS_A_UVOFS, 32'h00300040, 32'hFFFFFFFF);
    rdm(`OFS_A_RESP, 32'h155, 32'hFFFFFFFF);
    rdm(`OFS_A_MASK, 32'h0, 32'hFFFFFFFF);
    rdm(8'h40, 32'h0, 32'hFFFFFFFF);
    chk(e, 1'b1);
    biasMv <= 12'hED8;
    supplyGood <= 1'b1;
    waitOn(1, 7000);
    chk(phaseForceLow, 1'b1);
    // alert lags the status bit by one register
    @(posedge clk);
    chk(alertN, 1'b0);
    initDone <= 1'b1;
    biasMv <= 12'h000;
    enablePin <= 1'b1;
    wr(`OFS_A_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    chk(convertOn, 1'b0);
    supplyGood <= 1'b0;
    repeat (5) @(posedge clk);
    supplyGood <= 1'b1;
    wr(`OFS_A_CTRL, 32'h3);
    waitOn(0, 400);
    chk(setpointCode, 32'h384);
    // short window above the maximum
    wr(`OFS_A_TARGET, 32'hB00);
    repeat (4) @(posedge clk);
    chk(setpointCode, 32'hA8C);
    rdm(`OFS_A_STATUS, 32'h80, 32'h80);
    wr(`OFS_A_TARGET, 32'h384);
    // offsets relative to target plus 16 mV droop
    errMv <= 12'h048;
    repeat (60) @(posedge clk);
    rdm(`OFS_A_STATUS, 32'h8, 32'hC);
    chk(powerGoodOut, 1'b1);
    errMv <= 12'h060;
    waitOn(3, 60);
    chk(phaseForceLow, 1'b1);
    chk(faultOutputN, 1'b0);
    errMv <= 12'h000;
    repeat (300) @(posedge clk);
    rdm(`OFS_A_STATE, 32'h4, 32'h7);
    wr(`OFS_A_CTRL, 32'h3);
    waitOn(0, 400);
    wr(`OFS_A_RESP, 32'h165);
    errMv <= 12'hFD8;
    repeat (60) @(posedge clk);
    rdm(`OFS_A_STATUS, 32'h10, 32'h30);
    errMv <= 12'hFC0;
    waitOn(3, 60);
    chk(phaseTristate, 1'b1);
    waitOn(2, 400);
    chk(waited > 150, 1'b1);
    errMv <= 12'h000;
    waitOn(0, 400);
    wr(`OFS_A_RESP, 32'h125);
    loadAmps <= 8'h90;
    waitOn(4, 60);
    repeat (3600) @(posedge clk);
    rdm(`OFS_A_STATUS, 32'h300, 32'h300);
    chk(powerGoodOut, 1'b1);
    loadAmps <= 8'h10;
    chk(alertN, 1'b0);
    wr(`OFS_A_MASK, 32'h3FF);
    repeat (3) @(posedge clk);
    chk(alertN, 1'b1);
    enablePin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(powerGoodOut, 1'b0);
    // zero turn-on budget expires on the first soft-start cycle
    wr(`OFS_A_LIMITS, 32'h00500E74);
    enablePin <= 1'b1;
    repeat (8) @(posedge clk);
    rdm(`OFS_A_STATE, 32'h4, 32'h7);
    rdm(`OFS_A_STATUS, 32'h40, 32'h40);
    enablePin <= 1'b0;
    // overvoltage while idle must survive a clear
    biasMv <= 12'hF00;
    repeat (40) @(posedge clk);
    biasMv <= 12'h000;
    wr(`OFS_A_CTRL, 32'h3);
    enablePin <= 1'b1;
    repeat (60) @(posedge clk);
    chk(convertOn, 1'b0);
    rdm(`OFS_A_STATE, 32'h200, 32'h200);
    stop_test();
  end
endmodule // tb
`default_nettype wire
